// ===== ccr_pkg.sv
/*
  Package for the charger configuration register bank: register offsets,
  reset values, field positions, decoded settings, timing constants and the
  state and carrier types shared by the bank and its host timeout timer.
  Assumes a single 40 MHz clock domain.
*/
package ccr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and time base.
  localparam int unsigned CLOCK_HZ    = 40_000_000;
  localparam int unsigned TICK_S      = 1;
  localparam int unsigned TICK_CYCLES = CLOCK_HZ * TICK_S;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets and reset values.
  localparam logic [7:0] VLIM_OFS  = 8'h04;
  localparam logic [7:0] TTC_OFS   = 8'h05;
  localparam logic [7:0] IPC_OFS   = 8'h06;
  localparam logic [7:0] VLIM_RST  = 8'h58;
  localparam logic [7:0] TTC_RST   = 8'h9f;
  localparam logic [7:0] IPC_RST   = 8'he6;
  localparam logic [7:0] UNMAPPED  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int VCODE_LSB = 3;
  localparam int EXT_LSB   = 1;
  localparam int RECHG_BIT = 0;
  localparam int TERM_BIT  = 7;
  localparam int REARM_BIT = 6;
  localparam int TMO_LSB   = 4;
  localparam int SAFE_BIT  = 3;
  localparam int LEN_BIT   = 2;
  localparam int TEMP_BIT  = 1;
  localparam int COLD_BIT  = 0;
  localparam int OVP_LSB   = 6;
  localparam int OTG_LSB   = 4;
  localparam int FLOOR_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded values.
  localparam logic [4:0]  VCODE_MAX     = 5'h18;
  localparam logic [4:0]  VCODE_SPECIAL = 5'h0f;
  localparam logic [12:0] VBASE_MV      = 13'hf10;
  localparam logic [12:0] VSTEP_MV      = 13'h020;
  localparam logic [12:0] VSPECIAL_MV   = 13'h1100;
  localparam logic [7:0]  RECHG_LO_MV   = 8'h64;
  localparam logic [7:0]  RECHG_HI_MV   = 8'hc8;
  localparam logic [7:0]  TERMINATION_CURRENT_LONG_MS = 8'hc8;
  localparam logic [7:0]  TERMINATION_CURRENT_SHORT_MS = 8'h10;
  localparam logic [7:0]  TMO_40_S      = 8'h28;
  localparam logic [7:0]  TMO_80_S      = 8'h50;
  localparam logic [7:0]  TMO_160_S     = 8'ha0;
  localparam logic [4:0]  SAFE_SHORT_H  = 5'h07;
  localparam logic [4:0]  SAFE_LONG_H   = 5'h10;
  localparam logic [6:0]  TEMP_LO_C     = 7'h50;
  localparam logic [6:0]  TEMP_HI_C     = 7'h78;
  localparam logic [6:0]  COLD_HALF_PCT = 7'h32;
  localparam logic [6:0]  COLD_LOW_PCT  = 7'h14;
  localparam logic [6:0]  FULL_PCT      = 7'h64;
  localparam logic [13:0] OVP_MV [4]    = '{14'h157c, 14'h1964, 14'h2904, 14'h36b0};
  localparam logic [12:0] OTG_MV [4]    = '{13'h12f2, 13'h1388, 13'h141e, 13'h14b4};
  localparam logic [13:0] FLOOR_MV [4]  = '{14'h0f3c, 14'h170c, 14'h1d4c, 14'h2904};
  localparam logic [13:0] FLOOR_STEP_MV = 14'h0064;

  ////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } ccr_i2c_st_t;

  typedef struct packed {
    logic [7:0] vlim;
    logic [7:0] ttc;
    logic [7:0] ipc;
  } ccr_regs_t;

  typedef struct packed {
    logic [4:0]  charge_voltage_code;
    logic [12:0] charge_voltage_mv;
    logic [1:0]  post_termination_extension;
    logic        post_term_ext_on;
    logic [7:0]  recharge_drop_mv;
    logic        termination_allow;
    logic        direct_path_clear;
    logic [7:0]  term_timer_ms;
    logic [1:0]  host_timeout_setting;
    logic        safety_timer_on;
    logic [4:0]  safety_timer_hours;
    logic [6:0]  die_temp_limit_c;
    logic [6:0]  cold_current_percent;
    logic [13:0] input_overvoltage_mv;
    logic [12:0] otg_output_mv;
    logic [13:0] input_voltage_floor_mv;
  } ccr_cfg_t;

  typedef struct packed {
    ccr_i2c_st_t st;
    logic        scl_q;
    logic        sda_q;
    logic [2:0]  bit_cnt;
    logic        byte_done;
    logic        rw;
    logic        nack;
    logic [7:0]  shift;
    logic [7:0]  ptr;
    logic        sda_oe;
    logic        sda_out;
    ccr_regs_t   regs;
    ccr_cfg_t    cfg;
  } ccr_state_t;

  typedef struct packed {
    logic [25:0] tick_cnt;
    logic [7:0]  sec_cnt;
    logic        expired;
    logic        clear_done;
  } ccr_tmo_state_t;

endpackage

// ===== ccr_host_timeout.sv
/*
  Host timeout timer for the charger configuration bank.
  Assumes a single clock; the clear level comes from the host-written bit.
*/
`timescale 1ns/10ps
module ccr_host_timeout
  import ccr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Control.
  input  wire logic [1:0] setting,
  input  wire logic       clear,
  // Events.
  output logic            expired,
  output logic            clear_done
);

  ccr_tmo_state_t s;
  ccr_tmo_state_t next_s;
  logic [7:0]     limit_s;

  ////////////////////////////////////////////////////////////////////////////
  // Period select and counting.
  always_comb
  begin
    next_s = s;
    next_s.expired = 1'b0;
    next_s.clear_done = 1'b0;
    case (setting)
      2'h1:    limit_s = TMO_40_S;
      2'h2:    limit_s = TMO_80_S;
      2'h3:    limit_s = TMO_160_S;
      default: limit_s = 8'h00;
    endcase
    if (setting == 2'h0)
    begin
      next_s.tick_cnt = 26'h0;
      next_s.sec_cnt = 8'h00;
      next_s.clear_done = clear;
    end
    else if (clear)
    begin
      next_s.tick_cnt = 26'h0;
      next_s.sec_cnt = 8'h00;
      next_s.clear_done = 1'b1;
    end
    else if (s.tick_cnt == 26'(TICK_CYCLES_P - 1))
    begin
      next_s.tick_cnt = 26'h0;
      if (s.sec_cnt + 8'h01 >= limit_s)
      begin
        next_s.sec_cnt = 8'h00;
        next_s.expired = 1'b1;
      end
      else
      begin
        next_s.sec_cnt = s.sec_cnt + 8'h01;
      end
    end
    else
    begin
      next_s.tick_cnt = s.tick_cnt + 26'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign expired    = s.expired;
  assign clear_done = s.clear_done;

endmodule // ccr_host_timeout

// ===== ccr_config_bank.sv
/*
  Charger configuration register bank at offsets 0x04 to 0x06, written and
  read by the host over an I2C slave port, with decoded settings out.
  Assumes SCL and SDA are already synchronous to the 40 MHz clock and that
  the SDA wire is resolved outside from sda_oe (open drain, low when set).
*/
`timescale 1ns/10ps
module ccr_config_bank
  import ccr_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR      = 7'h6b, // Arbitrary slave address.
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst_n,
  // I2C pins.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Charger status and control bits kept elsewhere.
  input  wire logic       reg_reset_cmd,
  input  wire logic       host_timeout_clear,
  input  wire logic       direct_charge_path_on,
  input  wire logic       input_overcurrent,
  input  wire logic       cold_current_reduce_allow,
  input  wire logic [1:0] input_voltage_floor_offset,
  // Decoded settings and events.
  output ccr_cfg_t        cfg,
  output logic            host_timeout_expired,
  output logic            host_timeout_clear_done
);

  ccr_state_t s;
  ccr_state_t next_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       tmo_expired;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.
  function automatic logic [4:0] eff_code(input logic [4:0] code);
    eff_code = (code > VCODE_MAX) ? VCODE_MAX : code;
  endfunction

  function automatic logic [12:0] code_mv(input logic [4:0] code);
    if (code == VCODE_SPECIAL)
    begin
      code_mv = VSPECIAL_MV;
    end
    else
    begin
      code_mv = 13'(VBASE_MV + 13'(VSTEP_MV * 13'(code)));
    end
  endfunction

  function automatic logic [7:0] read_reg(input ccr_regs_t r, input logic [7:0] a);
    if (a == VLIM_OFS)
    begin
      read_reg = r.vlim;
    end
    else if (a == TTC_OFS)
    begin
      read_reg = r.ttc;
    end
    else if (a == IPC_OFS)
    begin
      read_reg = r.ipc;
    end
    else
    begin
      read_reg = UNMAPPED;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host timeout timer.
  ccr_host_timeout #(
    .TICK_CYCLES_P (TICK_CYCLES_P)
  ) u_timeout (
    .clock      (clock),
    .rst_n      (rst_n),
    .setting    (s.regs.ttc[TMO_LSB +: 2]),
    .clear      (host_timeout_clear),
    .expired    (tmo_expired),
    .clear_done (host_timeout_clear_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection.
  assign scl_rise   = scl_in & ~s.scl_q;
  assign scl_fall   = ~scl_in & s.scl_q;
  assign start_cond = scl_in & s.scl_q & s.sda_q & ~sda_in;
  assign stop_cond  = scl_in & s.scl_q & ~s.sda_q & sda_in;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb
  begin
    logic       wr_en;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [4:0] code;
    wr_en = 1'b0;
    wr_data = 8'h00;
    rd_data = read_reg(s.regs, s.ptr);
    code = 5'h00;
    next_s = s;
    next_s.scl_q = scl_in;
    next_s.sda_q = sda_in;
    next_s.sda_out = 1'b0;

    // Serial protocol.
    if (start_cond)
    begin
      next_s.st = ST_ADDR;
      next_s.bit_cnt = 3'h0;
      next_s.byte_done = 1'b0;
      next_s.sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      next_s.st = ST_IDLE;
      next_s.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (s.st)
        ST_ADDR, ST_PTR, ST_WR, ST_RD:
        begin
          next_s.bit_cnt = s.bit_cnt + 3'h1;
          next_s.byte_done = (s.bit_cnt == 3'h7);
          if (s.st != ST_RD)
          begin
            next_s.shift = {s.shift[6:0], sda_in};
          end
        end
        ST_RD_ACK:
        begin
          next_s.nack = sda_in;
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      case (s.st)
        ST_ADDR:
        begin
          if (s.byte_done)
          begin
            next_s.byte_done = 1'b0;
            if (s.shift[7:1] == DEV_ADDR)
            begin
              next_s.st = ST_ADDR_ACK;
              next_s.rw = s.shift[0];
              next_s.sda_oe = 1'b1;
            end
            else
            begin
              next_s.st = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK:
        begin
          if (s.rw)
          begin
            next_s.st = ST_RD;
            next_s.shift = rd_data;
            next_s.sda_oe = ~rd_data[7];
            next_s.ptr = s.ptr + 8'h01;
          end
          else
          begin
            next_s.st = ST_PTR;
            next_s.sda_oe = 1'b0;
          end
        end
        ST_PTR:
        begin
          if (s.byte_done)
          begin
            next_s.byte_done = 1'b0;
            next_s.ptr = s.shift;
            next_s.st = ST_PTR_ACK;
            next_s.sda_oe = 1'b1;
          end
        end
        ST_WR:
        begin
          if (s.byte_done)
          begin
            next_s.byte_done = 1'b0;
            wr_en = 1'b1;
            wr_data = s.shift;
            next_s.ptr = s.ptr + 8'h01;
            next_s.st = ST_WR_ACK;
            next_s.sda_oe = 1'b1;
          end
        end
        ST_PTR_ACK, ST_WR_ACK:
        begin
          next_s.st = ST_WR;
          next_s.sda_oe = 1'b0;
        end
        ST_RD:
        begin
          if (s.byte_done)
          begin
            next_s.byte_done = 1'b0;
            next_s.st = ST_RD_ACK;
            next_s.sda_oe = 1'b0;
          end
          else
          begin
            next_s.shift = {s.shift[6:0], 1'b0};
            next_s.sda_oe = ~s.shift[6];
          end
        end
        ST_RD_ACK:
        begin
          if (s.nack)
          begin
            next_s.st = ST_IDLE;
          end
          else
          begin
            next_s.st = ST_RD;
            next_s.shift = rd_data;
            next_s.sda_oe = ~rd_data[7];
            next_s.ptr = s.ptr + 8'h01;
          end
        end
        default:
        begin
          next_s.sda_oe = 1'b0;
        end
      endcase
    end

    // Register file.
    if (reg_reset_cmd)
    begin
      next_s.regs.vlim = VLIM_RST;
      next_s.regs.ttc = TTC_RST;
      next_s.regs.ipc = IPC_RST;
    end
    else
    begin
      if (wr_en)
      begin
        if (s.ptr == VLIM_OFS)
        begin
          next_s.regs.vlim = wr_data;
        end
        else if (s.ptr == TTC_OFS)
        begin
          next_s.regs.ttc = wr_data;
        end
        else if (s.ptr == IPC_OFS)
        begin
          next_s.regs.ipc = wr_data;
        end
      end
      if (tmo_expired)
      begin
        next_s.regs.vlim = VLIM_RST;
        next_s.regs.ttc = TTC_RST;
      end
    end

    // Decoded settings.
    code = eff_code(s.regs.vlim[VCODE_LSB +: 5]);
    next_s.cfg.charge_voltage_code = code;
    next_s.cfg.charge_voltage_mv = code_mv(code);
    next_s.cfg.post_termination_extension = s.regs.vlim[EXT_LSB +: 2];
    next_s.cfg.post_term_ext_on = (s.regs.vlim[EXT_LSB +: 2] != 2'h0);
    next_s.cfg.recharge_drop_mv = s.regs.vlim[RECHG_BIT] ? RECHG_HI_MV : RECHG_LO_MV;
    next_s.cfg.termination_allow = s.regs.ttc[TERM_BIT];
    next_s.cfg.direct_path_clear = direct_charge_path_on & input_overcurrent
                                   & ~s.regs.ttc[REARM_BIT];
    if (direct_charge_path_on)
    begin
      next_s.cfg.term_timer_ms = 8'h00;
    end
    else
    begin
      next_s.cfg.term_timer_ms = s.regs.ttc[REARM_BIT] ? TERMINATION_CURRENT_SHORT_MS : TERMINATION_CURRENT_LONG_MS;
    end
    next_s.cfg.host_timeout_setting = s.regs.ttc[TMO_LSB +: 2];
    next_s.cfg.safety_timer_on = s.regs.ttc[SAFE_BIT];
    next_s.cfg.safety_timer_hours = s.regs.ttc[LEN_BIT] ? SAFE_LONG_H : SAFE_SHORT_H;
    next_s.cfg.die_temp_limit_c = s.regs.ttc[TEMP_BIT] ? TEMP_HI_C : TEMP_LO_C;
    if (cold_current_reduce_allow)
    begin
      next_s.cfg.cold_current_percent = s.regs.ttc[COLD_BIT] ? COLD_LOW_PCT : COLD_HALF_PCT;
    end
    else
    begin
      next_s.cfg.cold_current_percent = FULL_PCT;
    end
    next_s.cfg.input_overvoltage_mv = OVP_MV[s.regs.ipc[OVP_LSB +: 2]];
    next_s.cfg.otg_output_mv = OTG_MV[s.regs.ipc[OTG_LSB +: 2]];
    next_s.cfg.input_voltage_floor_mv = 14'(FLOOR_MV[input_voltage_floor_offset]
      + 14'(FLOOR_STEP_MV * 14'(s.regs.ipc[FLOOR_LSB +: 4])));
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st <= ST_IDLE;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.regs.vlim <= VLIM_RST;
      s.regs.ttc <= TTC_RST;
      s.regs.ipc <= IPC_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expiry pulse out.
  logic expired_q;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      expired_q <= 1'b0;
    end
    else
    begin
      expired_q <= tmo_expired;
    end
  end

  assign sda_out              = s.sda_out;
  assign sda_oe               = s.sda_oe;
  assign cfg                  = s.cfg;
  assign host_timeout_expired = expired_q;

endmodule // ccr_config_bank

// ===== ccr_config_bank_props.sv
/*
  Checker for the charger configuration bank, bound to its ports.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module ccr_config_bank_chk
  import ccr_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR      = 7'h6b, // Arbitrary slave address.
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset.
  input wire logic       clock,
  input wire logic       rst_n,
  // I2C pins.
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Control inputs.
  input wire logic       reg_reset_cmd,
  input wire logic       host_timeout_clear,
  input wire logic       direct_charge_path_on,
  input wire logic       input_overcurrent,
  input wire logic       cold_current_reduce_allow,
  input wire logic [1:0] input_voltage_floor_offset,
  // Settings and events.
  input wire ccr_cfg_t   cfg,
  input wire logic       host_timeout_expired,
  input wire logic       host_timeout_clear_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Counts the edges until the decoded settings are valid.
  logic [1:0] up;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_after_release; $rose(rst_n) ##2 1'b1; endsequence
  sequence s_clear_held; host_timeout_clear [*3]; endsequence
  sequence s_reset_cmd; reg_reset_cmd ##3 1'b1; endsequence

  property p_defaults;
    s_after_release |-> cfg.charge_voltage_mv == 13'h1070 && cfg.host_timeout_setting == 2'h1
      && cfg.safety_timer_hours == 5'h10 && cfg.input_overvoltage_mv == 14'h36b0;
  endproperty
  a_defaults: assert property (p_defaults) else $error("settings after reset wrong");
  property p_mv_decode;
    up == 2'h3 |-> cfg.charge_voltage_mv == ((cfg.charge_voltage_code == 5'h0f) ? 13'h1100
      : 13'hf10 + 13'h20 * cfg.charge_voltage_code);
  endproperty
  a_mv_decode: assert property (p_mv_decode) else $error("voltage limit decode wrong");
  property p_code_clamp; cfg.charge_voltage_code <= 5'h18; endproperty
  a_code_clamp: assert property (p_code_clamp) else $error("voltage code above top");
  property p_ext_on; cfg.post_term_ext_on == (cfg.post_termination_extension != 2'h0); endproperty
  a_ext_on: assert property (p_ext_on) else $error("extension flag wrong");
  property p_path_clear; cfg.direct_path_clear |-> cfg.term_timer_ms == 8'h00; endproperty
  a_path_clear: assert property (p_path_clear) else $error("timer shown with path on");
  property p_cold; (up == 2'h3 && !cold_current_reduce_allow) [*3] |-> cfg.cold_current_percent == 7'h64; endproperty
  a_cold: assert property (p_cold) else $error("cold reduction without allow");
  property p_clear_done; host_timeout_clear |=> host_timeout_clear_done; endproperty
  a_clear_done: assert property (p_clear_done) else $error("clear not acknowledged");
  property p_no_expiry_cleared; s_clear_held |-> !host_timeout_expired; endproperty
  a_no_expiry_cleared: assert property (p_no_expiry_cleared) else $error("expiry while cleared");
  property p_expiry_single; host_timeout_expired |=> !host_timeout_expired; endproperty
  a_expiry_single: assert property (p_expiry_single) else $error("expiry pulse too long");
  property p_expiry_restores;
    host_timeout_expired |-> ##1 cfg.charge_voltage_mv == 13'h1070 && cfg.termination_allow;
  endproperty
  a_expiry_restores: assert property (p_expiry_restores) else $error("expiry kept old values");
  property p_reset_cmd;
    s_reset_cmd |-> cfg.charge_voltage_mv == 13'h1070 && cfg.input_overvoltage_mv == 14'h36b0;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command kept old values");
endmodule // ccr_config_bank_chk

bind ccr_config_bank ccr_config_bank_chk #(.DEV_ADDR(DEV_ADDR), .TICK_CYCLES_P(TICK_CYCLES_P)) chk_u (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .reg_reset_cmd(reg_reset_cmd), .host_timeout_clear(host_timeout_clear),
  .direct_charge_path_on(direct_charge_path_on), .input_overcurrent(input_overcurrent),
  .cold_current_reduce_allow(cold_current_reduce_allow),
  .input_voltage_floor_offset(input_voltage_floor_offset), .cfg(cfg),
  .host_timeout_expired(host_timeout_expired), .host_timeout_clear_done(host_timeout_clear_done));

// ===== ccr_host_model.sv
/*
  I2C host model that writes and reads the bank's registers.
  Assumes the bench resolves the open-drain SDA line with a pull-up.
*/
`timescale 1ns/10ps
module ccr_host_model
#(
  parameter logic [6:0] ADDR = 7'h6b
)
(
  // Clock.
  input  wire logic clock,
  // Bus.
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Each SCL phase lasts four clocks.
  task automatic bit_io(input logic d, output logic q);
    @(posedge clock);
    sda_low <= ~d;
    repeat (3) @(posedge clock);
    scl <= 1'b1;
    repeat (3) @(posedge clock);
    q = sda_line;
    @(posedge clock);
    scl <= 1'b0;
  endtask

  task automatic start();
    @(posedge clock);
    sda_low <= 1'b0;
    repeat (3) @(posedge clock);
    scl <= 1'b1;
    repeat (3) @(posedge clock);
    sda_low <= 1'b1;
    repeat (3) @(posedge clock);
    scl <= 1'b0;
  endtask

  task automatic stop();
    @(posedge clock);
    sda_low <= 1'b1;
    repeat (3) @(posedge clock);
    scl <= 1'b1;
    repeat (3) @(posedge clock);
    sda_low <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, k[0]);
    xfer(a, 1'b1, q, k[1]);
    xfer(d, 1'b1, q, k[2]);
    stop();
    ok = (k === 3'h0);
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [3:0] k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, k[0]);
    xfer(a, 1'b1, q, k[1]);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q, k[2]);
    xfer(8'hff, 1'b1, d, k[3]);
    stop();
    ok = (k[2:0] === 3'h0);
  endtask
endmodule // ccr_host_model

// ===== charger_config_regs_04_06_tb.sv
/*
  Testbench for the charger configuration bank, driven through the I2C host model.
  Assumes a 40 MHz clock and a shortened second of 20 clocks.
*/
`timescale 1ns/10ps
module charger_config_regs_04_06_tb;
  import ccr_pkg::*;
  localparam int LIMIT = 60000;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       rrc   = 1'b0;
  logic       clr   = 1'b1;
  logic       pon   = 1'b0;
  logic       oc    = 1'b0;
  logic       cold  = 1'b1;
  logic [1:0] fofs  = 2'h0;
  logic       scl;
  logic       sda_low;
  logic       sda_oe;
  logic       expired;
  ccr_cfg_t   cfg;
  int         errors = 0;
  int         n_compared = 0;
  int         cycles = 0;
  wire        sda_line = ~(sda_oe | sda_low);
  logic [4:0] vc [6] = '{5'h00, 5'h0e, 5'h0f, 5'h18, 5'h19, 5'h1f};
  logic [7:0] tv [4] = '{8'h00, 8'h5a, 8'ha5, 8'hff};
  logic [7:0] pv [4] = '{8'h00, 8'h5f, 8'ha9, 8'hf0};

  always #12.5 clock = ~clock;

  ccr_config_bank #(.TICK_CYCLES_P(20)) dut_u (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .reg_reset_cmd(rrc), .host_timeout_clear(clr), .direct_charge_path_on(pon), .input_overcurrent(oc),
    .cold_current_reduce_allow(cold), .input_voltage_floor_offset(fofs), .cfg(cfg),
    .host_timeout_expired(expired), .host_timeout_clear_done());
  ccr_host_model host_u (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host_u.write_reg(a, d, ok);
    check(16'(ok), 16'h1);
    repeat (4) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       ok;
    host_u.read_reg(a, q, ok);
    check(16'(ok), 16'h1);
    check(16'(q), 16'(exp));
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      errors++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [4:0] e;
    logic [7:0] v;
    int         k;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rd(VLIM_OFS, VLIM_RST);
    rd(TTC_OFS, TTC_RST);
    rd(IPC_OFS, IPC_RST);
    check(16'(cfg.recharge_drop_mv), 16'(RECHG_LO_MV));
    check(16'(cfg.input_voltage_floor_mv), 16'h1194);
    $display("test defaults done");
    foreach (vc[i])
    begin
      e = (vc[i] > 5'h18) ? 5'h18 : vc[i];
      wr(VLIM_OFS, {vc[i], vc[i][2:0]});
      rd(VLIM_OFS, {vc[i], vc[i][2:0]});
      check(16'(cfg.charge_voltage_code), 16'(e));
      check(16'(cfg.charge_voltage_mv), 16'((e == 5'h0f) ? VSPECIAL_MV : VBASE_MV + VSTEP_MV * e));
      check(16'(cfg.post_term_ext_on), 16'(|vc[i][2:1]));
      check(16'(cfg.recharge_drop_mv), 16'(vc[i][0] ? RECHG_HI_MV : RECHG_LO_MV));
    end
    $display("test voltage done");
    foreach (tv[i])
    begin
      v = tv[i];
      wr(TTC_OFS, v);
      check(16'(cfg.termination_allow), 16'(v[7]));
      check(16'(cfg.term_timer_ms), 16'(v[6] ? TERMINATION_CURRENT_SHORT_MS : TERMINATION_CURRENT_LONG_MS));
      check(16'(cfg.host_timeout_setting), 16'(v[5:4]));
      check(16'(cfg.safety_timer_on), 16'(v[3]));
      check(16'(cfg.safety_timer_hours), 16'(v[2] ? SAFE_LONG_H : SAFE_SHORT_H));
      check(16'(cfg.die_temp_limit_c), 16'(v[1] ? TEMP_HI_C : TEMP_LO_C));
      check(16'(cfg.cold_current_percent), 16'(v[0] ? COLD_LOW_PCT : COLD_HALF_PCT));
      pon <= 1'b1;
      oc <= 1'b1;
      cold <= 1'b0;
      repeat (4) @(posedge clock);
      check(16'(cfg.direct_path_clear), 16'(!v[6]));
      check(16'(cfg.cold_current_percent), 16'(FULL_PCT));
      pon <= 1'b0;
      oc <= 1'b0;
      cold <= 1'b1;
    end
    $display("test control done");
    foreach (pv[i])
    begin
      fofs <= 2'(i);
      wr(IPC_OFS, pv[i]);
      check(16'(cfg.input_overvoltage_mv), 16'(OVP_MV[pv[i][7:6]]));
      check(16'(cfg.otg_output_mv), 16'(OTG_MV[pv[i][5:4]]));
      check(16'(cfg.input_voltage_floor_mv), 16'(FLOOR_MV[i] + FLOOR_STEP_MV * pv[i][3:0]));
    end
    wr(8'h07, 8'h5a);
    rd(8'h07, UNMAPPED);
    rd(IPC_OFS, 8'hf0);
    $display("test protection done");
    rrc <= 1'b1;
    @(posedge clock);
    rrc <= 1'b0;
    repeat (4) @(posedge clock);
    rd(VLIM_OFS, VLIM_RST);
    rd(TTC_OFS, TTC_RST);
    rd(IPC_OFS, IPC_RST);
    $display("test reset command done");
    wr(VLIM_OFS, 8'h00);
    wr(TTC_OFS, 8'h1f);
    wr(IPC_OFS, 8'h00);
    clr <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clock);
      k++;
    end
    while (expired !== 1'b1 && k < 2000);
    check(16'(k >= 780 && k <= 820), 16'h1);
    @(posedge clock);
    clr <= 1'b1;
    repeat (4) @(posedge clock);
    rd(VLIM_OFS, VLIM_RST);
    rd(TTC_OFS, TTC_RST);
    rd(IPC_OFS, 8'h00);
    $display("test timeout done");
    summarize();
  end
endmodule // charger_config_regs_04_06_tb
